// ==== dpr_assertions.sv ====
// Wire checker for the DDR2 command link between controller and device.
// Assumes it stands beside the link interface and sees its signals as inputs.
`timescale 1ns/1ps
`include "dpr_params.svh"
module dpr_assertions (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr
);
   logic cke_reg;
   logic [3:0] open_reg;
   logic [3:0] open_next;
   logic cv, idle, rd, wr, pre, act, rf;
   // A command only counts when CKE was high on this edge and the one before.
   assign cv = cke && cke_reg && !cs_n;
   assign idle = cs_n || (ras_n && cas_n && we_n);
   assign rd = cv && ras_n && !cas_n && we_n;
   assign wr = cv && ras_n && !cas_n && !we_n;
   assign pre = cv && !ras_n && cas_n && !we_n;
   assign act = cv && !ras_n && cas_n && we_n;
   assign rf = cv && !ras_n && !cas_n && we_n;
   always_comb begin
      open_next = open_reg;
      if (act) begin
         open_next[ba] = 1'b1;
      end else if (pre && addr[`DPR_A10]) begin
         open_next = 4'h0;
      end else if (pre || ((rd || wr) && addr[`DPR_A10])) begin
         open_next[ba] = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      cke_reg <= sys_rst || cke;
      open_reg <= sys_rst ? 4'h0 : open_next;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_rd_pre;
      rd |=> !pre;
   endproperty
   property p_wr_pre;
      wr |=> !pre [*4];
   endproperty
   property p_rw_gap;
      (rd || wr) |=> !(rd || wr);
   endproperty
   property p_cke_fall;
      $fell(cke) |-> idle || (!cs_n && !ras_n && !cas_n && we_n && open_reg == 4'h0);
   endproperty
   property p_rw_cke;
      (rd || wr) |=> cke [*2];
   endproperty
   property p_cke_low;
      $fell(cke) |=> !cke [*2];
   endproperty
   property p_pd_exit;
      $rose(cke) |-> idle ##1 (cke && idle) ##1 cke;
   endproperty
   property p_ref_idle;
      rf |-> open_reg == 4'h0;
   endproperty
   a_rd_pre: assert property (p_rd_pre) else $error("precharge soon after read");
   a_wr_pre: assert property (p_wr_pre) else $error("precharge soon after write");
   a_rw_gap: assert property (p_rw_gap) else $error("burst cut short");
   a_cke_fall: assert property (p_cke_fall) else $error("bad command at cke fall");
   a_rw_cke: assert property (p_rw_cke) else $error("cke low during burst");
   a_cke_low: assert property (p_cke_low) else $error("cke low too short");
   a_pd_exit: assert property (p_pd_exit) else $error("bad power-down exit");
   a_ref_idle: assert property (p_ref_idle) else $error("refresh with open bank");
   c_rd_pre: cover property (rd ##[1:20] pre);
   c_pd: cover property ($fell(cke) ##[3:200] $rose(cke));
   c_ref: cover property (rf);
endmodule : dpr_assertions

// ==== dpr_bus.sv ====
// Command link between a DDR2 controller and the device: CKE, command pins,
// bank and address lines and ODT. All pins are driven by the controller only.
`timescale 1ns/1ps
interface dpr_bus;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic odt;
   logic [1:0] ba;
   logic [12:0] addr;
   modport ctl (output cke, output cs_n, output ras_n, output cas_n, output we_n,
                output odt, output ba, output addr);
   modport dev (input cke, input cs_n, input ras_n, input cas_n, input we_n,
                input odt, input ba, input addr);
endinterface : dpr_bus

// ==== dpr_ctl.sv ====
// Controller end: takes one user request at a time, holds it until every
// spacing rule allows it, then drives it on the link for one cycle.
// Assumes the user keeps cmd fields stable only in the accepting cycle.
`timescale 1ns/1ps
`include "dpr_params.svh"
module dpr_ctl #(
   parameter int REF_WIN_CYC = `DPR_REF_WIN_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   dpr_bus.ctl bus,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd,
   input wire logic [1:0] cmd_bank,
   input wire logic cmd_a10,
   input wire logic [12:0] cmd_addr,
   input wire logic dll_locked,
   input wire logic odt_req,
   input wire logic clk_chg,
   output logic cmd_ready,
   output logic ref_due,
   output logic in_pd,
   output logic freq_ok,
   output logic dll_rst_need
);
   localparam logic [11:0] TREFI = 12'(REF_WIN_CYC / `DPR_ROWS);
   localparam logic [11:0] PD_MAX = 12'(`DPR_PD_MAX_REFI * (REF_WIN_CYC / `DPR_ROWS));

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic odt;
      logic [1:0] ba;
      logic [12:0] addr;
      logic pend;
      dpr_pkg::dpr_req_t pcmd;
      logic [1:0] pbank;
      logic pa10;
      logic [12:0] paddr;
      logic ready;
      logic [3:0][7:0] pre_wait;
      logic [3:0][7:0] rp_cnt;
      logic [3:0] open;
      logic [7:0] rw_cnt;
      logic [11:0] refi_cnt;
      logic ref_due;
      logic in_pd;
      logic [7:0] cke_hold;
      logic [11:0] pd_cnt;
      logic [7:0] xp_cnt;
      logic [7:0] low_cnt;
      logic dll_rst_need;
      logic odt_block;
      logic [7:0] lock_cnt;
      logic freq_ok;
   } dpr_ctl_st_t;

   localparam dpr_ctl_st_t RST = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                  we_n: 1'b1, ready: 1'b1, pcmd: dpr_pkg::DPR_Q_ACT,
                                  default: '0};

   dpr_ctl_st_t r;
   dpr_ctl_st_t n;
   logic all_idle;
   logic go;

   function automatic logic [7:0] dpr_dec(input logic [7:0] v);
      return (v == 8'h00) ? 8'h00 : v - 8'h01;
   endfunction : dpr_dec

   function automatic logic [7:0] dpr_max(input logic [7:0] a, input logic [7:0] b);
      return (a > b) ? a : b;
   endfunction : dpr_max

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      go = 1'b0;
      all_idle = (r.open == 4'h0);
      // The link idles with NOP; one command per cycle at most.
      n.cs_n = 1'b0;
      n.ras_n = 1'b1;
      n.cas_n = 1'b1;
      n.we_n = 1'b1;
      for (int b = 0; b < 4; b++) begin
         n.pre_wait[b] = dpr_dec(r.pre_wait[b]);
         n.rp_cnt[b] = dpr_dec(r.rp_cnt[b]);
         all_idle = all_idle && (r.rp_cnt[b] == 8'h00);
      end
      n.rw_cnt = dpr_dec(r.rw_cnt);
      n.cke_hold = dpr_dec(r.cke_hold);
      n.xp_cnt = dpr_dec(r.xp_cnt);
      n.lock_cnt = dpr_dec(r.lock_cnt);
      // Refresh timer; the sticky flag is only cleared when a refresh goes out.
      if (r.refi_cnt >= TREFI - 12'h001) begin
         n.refi_cnt = 12'h000;
         n.ref_due = 1'b1;
      end else begin
         n.refi_cnt = r.refi_cnt + 12'h001;
      end
      if (r.in_pd) begin
         n.pd_cnt = r.pd_cnt + 12'h001;
         n.low_cnt = (r.low_cnt == 8'hFF) ? r.low_cnt : r.low_cnt + 8'h01;
         if (clk_chg) begin
            n.dll_rst_need = 1'b1;
            n.odt_block = 1'b1;
         end
      end
      if (r.odt_block && !n.dll_rst_need && r.lock_cnt == 8'h00) begin
         n.odt_block = 1'b0;
      end
      if (cmd_valid && r.ready) begin
         n.pend = 1'b1;
         n.pcmd = dpr_pkg::dpr_req_t'(cmd);
         n.pbank = cmd_bank;
         n.pa10 = cmd_a10;
         n.paddr = cmd_addr;
      end
      if (r.in_pd) begin
         // No refresh happens in power-down, so a long stay is cut short here.
         if (r.cke_hold == 8'h00 && (r.pd_cnt >= PD_MAX ||
             (r.pend && r.pcmd == dpr_pkg::DPR_Q_PDX))) begin
            n.cke = 1'b1;
            n.in_pd = 1'b0;
            n.cke_hold = 8'(`DPR_TCKE);
            n.xp_cnt = 8'(`DPR_TXP);
            go = r.pend && r.pcmd == dpr_pkg::DPR_Q_PDX;
         end
      end else if (r.pend && r.xp_cnt == 8'h00 && r.cke_hold == 8'h00) begin
         unique case (r.pcmd)
            dpr_pkg::DPR_Q_ACT: begin
               if (!r.open[r.pbank] && r.rp_cnt[r.pbank] == 8'h00) begin
                  go = 1'b1;
                  {n.ras_n, n.cas_n, n.we_n} = 3'b011;
                  n.open[r.pbank] = 1'b1;
               end
            end
            dpr_pkg::DPR_Q_RD, dpr_pkg::DPR_Q_WR: begin
               // A new burst waits for the previous one; bursts are never cut.
               if (r.open[r.pbank] && r.rw_cnt == 8'h00) begin
                  go = 1'b1;
                  n.ras_n = 1'b1;
                  n.cas_n = 1'b0;
                  n.we_n = (r.pcmd == dpr_pkg::DPR_Q_RD);
                  n.rw_cnt = 8'(`DPR_BL / 2);
                  if (r.pcmd == dpr_pkg::DPR_Q_RD) begin
                     n.pre_wait[r.pbank] = dpr_max(r.pre_wait[r.pbank],
                                                   8'(`DPR_RD_PRE));
                  end else begin
                     n.pre_wait[r.pbank] = dpr_max(r.pre_wait[r.pbank],
                                                   8'(`DPR_WR_PRE));
                  end
                  if (r.pa10) begin
                     n.open[r.pbank] = 1'b0;
                     n.rp_cnt[r.pbank] = n.pre_wait[r.pbank] + 8'(`DPR_TRP);
                  end
               end
            end
            dpr_pkg::DPR_Q_PRE: begin
               if (r.pa10 ? (r.pre_wait == '0) : (r.pre_wait[r.pbank] == 8'h00)) begin
                  // Back-to-back precharges are legal since the gap is one clock.
                  go = 1'b1;
                  {n.ras_n, n.cas_n, n.we_n} = 3'b010;
                  for (int b = 0; b < 4; b++) begin
                     if (r.pa10 || r.pbank == 2'(b)) begin
                        n.open[b] = 1'b0;
                        n.rp_cnt[b] = 8'(`DPR_TRP);
                     end
                  end
               end
            end
            dpr_pkg::DPR_Q_REF: begin
               if (all_idle) begin
                  go = 1'b1;
                  {n.ras_n, n.cas_n, n.we_n} = 3'b001;
                  n.ref_due = (r.refi_cnt >= TREFI - 12'h001);
                  n.refi_cnt = 12'h000;
                  for (int b = 0; b < 4; b++) begin
                     n.rp_cnt[b] = 8'(`DPR_TRFC);
                  end
               end
            end
            dpr_pkg::DPR_Q_MRS: begin
               if (all_idle && r.rw_cnt == 8'h00) begin
                  go = 1'b1;
                  {n.ras_n, n.cas_n, n.we_n} = 3'b000;
                  n.cke_hold = 8'(`DPR_TCKE);
                  if (r.pbank == 2'h0 && r.paddr[`DPR_DLL_RST_BIT]) begin
                     n.dll_rst_need = 1'b0;
                     n.lock_cnt = 8'(`DPR_DLL_LOCK);
                  end
               end
            end
            dpr_pkg::DPR_Q_PDE: begin
               // CKE never falls during a burst or a mode register set.
               if (r.rw_cnt == 8'h00) begin
                  go = 1'b1;
                  n.cke = 1'b0;
                  n.in_pd = 1'b1;
                  n.pd_cnt = 12'h000;
                  n.low_cnt = 8'h00;
                  n.cke_hold = 8'(`DPR_TCKE);
                  n.dll_rst_need = r.dll_rst_need || !dll_locked;
               end
            end
            dpr_pkg::DPR_Q_PDX: begin
               go = 1'b1;
            end
            default: begin
               go = 1'b1;
            end
         endcase
      end
      if (go) begin
         n.pend = 1'b0;
         n.ba = r.pbank;
         n.addr = r.paddr;
         n.addr[`DPR_A10] = r.pa10;
      end
      n.ready = !n.pend;
      n.odt = odt_req && !n.odt_block;
      n.freq_ok = n.in_pd && r.in_pd && (r.open == 4'h0) && !n.odt &&
                  (r.low_cnt >= 8'(`DPR_FREQ_WAIT));
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   assign bus.cke = r.cke;
   assign bus.cs_n = r.cs_n;
   assign bus.ras_n = r.ras_n;
   assign bus.cas_n = r.cas_n;
   assign bus.we_n = r.we_n;
   assign bus.odt = r.odt;
   assign bus.ba = r.ba;
   assign bus.addr = r.addr;
   assign cmd_ready = r.ready;
   assign ref_due = r.ref_due;
   assign in_pd = r.in_pd;
   assign freq_ok = r.freq_ok;
   assign dll_rst_need = r.dll_rst_need;

endmodule : dpr_ctl

// ==== dpr_dev.sv ====
// Device end: decodes commands at the clock edge, tracks open banks, refresh
// row counter, power-down and self-refresh states. Assumes the controller keeps
// its own spacing obligations; illegal sequences are not flagged.
`timescale 1ns/1ps
`include "dpr_params.svh"
module dpr_dev (
   input wire logic mclk,
   input wire logic sys_rst,
   dpr_bus.dev bus,
   output logic [1:0] dev_state,
   output logic [3:0] bank_open,
   output logic dll_on,
   output logic buf_on,
   output logic lp_ok,
   output logic [12:0] ref_row,
   output logic [1:0] mr_sel,
   output logic [12:0] mr_op,
   output logic [3:0] cmd_code
);
   typedef struct packed {
      dpr_pkg::dpr_state_t st;
      logic cke_prev;
      logic [3:0] open;
      logic [7:0] op_cnt;
      logic [7:0] rw_cnt;
      logic slow_exit;
      logic dll_on;
      logic buf_on;
      logic lp_ok;
      logic [12:0] ref_row;
      logic [1:0] mr_sel;
      logic [12:0] mr_op;
      dpr_pkg::dpr_cmd_t cmd;
   } dpr_dev_st_t;

   localparam dpr_dev_st_t RST = '{st: dpr_pkg::DPR_S_NORM, cke_prev: 1'b1, dll_on: 1'b1,
                                  buf_on: 1'b1, cmd: dpr_pkg::DPR_C_NOP, default: '0};

   dpr_dev_st_t r;
   dpr_dev_st_t n;
   dpr_pkg::dpr_cmd_t c;
   logic quiet;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      c = dpr_pkg::dpr_decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n,
                              bus.addr[`DPR_A10]);
      quiet = (c == dpr_pkg::DPR_C_NOP) || (c == dpr_pkg::DPR_C_DSL);
      n = r;
      n.cke_prev = bus.cke;
      n.cmd = dpr_pkg::DPR_C_NOP;
      if (r.op_cnt != 8'h00) begin
         n.op_cnt = r.op_cnt - 8'h01;
      end
      if (r.rw_cnt != 8'h00) begin
         n.rw_cnt = r.rw_cnt - 8'h01;
      end
      unique case (r.st)
         dpr_pkg::DPR_S_NORM: begin
            if (r.cke_prev && bus.cke) begin
               n.cmd = c;
               unique case (c)
                  dpr_pkg::DPR_C_ACT: begin
                     n.open[bus.ba] = 1'b1;
                     n.op_cnt = 8'(`DPR_TRP);
                  end
                  dpr_pkg::DPR_C_PRE: begin
                     n.open[bus.ba] = 1'b0;
                     n.op_cnt = 8'(`DPR_TRP);
                  end
                  dpr_pkg::DPR_C_PREA: begin
                     n.open = 4'h0;
                     n.op_cnt = 8'(`DPR_TRP);
                  end
                  dpr_pkg::DPR_C_RD, dpr_pkg::DPR_C_WR: begin
                     n.rw_cnt = 8'(`DPR_BL / 2);
                  end
                  dpr_pkg::DPR_C_RDA: begin
                     n.rw_cnt = 8'(`DPR_BL / 2);
                     n.open[bus.ba] = 1'b0;
                     n.op_cnt = 8'(`DPR_RD_PRE + `DPR_TRP);
                  end
                  dpr_pkg::DPR_C_WRA: begin
                     n.rw_cnt = 8'(`DPR_BL / 2);
                     n.open[bus.ba] = 1'b0;
                     n.op_cnt = 8'(`DPR_WR_PRE + `DPR_TRP);
                  end
                  dpr_pkg::DPR_C_REF: begin
                     // The internal counter supplies the row; address pins are ignored.
                     n.ref_row = r.ref_row + 13'h0001;
                     n.op_cnt = 8'(`DPR_TRFC);
                  end
                  dpr_pkg::DPR_C_MRS: begin
                     n.mr_sel = bus.ba;
                     n.mr_op = bus.addr;
                     if (bus.ba == 2'h0) begin
                        n.slow_exit = bus.addr[`DPR_SLOW_EXIT_BIT];
                     end
                  end
                  default: begin
                  end
               endcase
            end else if (r.cke_prev && !bus.cke) begin
               if (c == dpr_pkg::DPR_C_REF && r.open == 4'h0) begin
                  n.st = dpr_pkg::DPR_S_SREF;
                  n.dll_on = 1'b0;
                  n.buf_on = 1'b0;
               end else if (quiet) begin
                  // Input buffers stop except clock, ODT and CKE.
                  n.buf_on = 1'b0;
                  if (r.open == 4'h0) begin
                     n.st = dpr_pkg::DPR_S_PPD;
                     n.dll_on = 1'b0;
                  end else begin
                     n.st = dpr_pkg::DPR_S_APD;
                     n.dll_on = !r.slow_exit;
                  end
               end
            end
         end
         dpr_pkg::DPR_S_PPD, dpr_pkg::DPR_S_APD: begin
            if (bus.cke && quiet) begin
               n.st = dpr_pkg::DPR_S_NORM;
               n.dll_on = 1'b1;
               n.buf_on = 1'b1;
            end
         end
         dpr_pkg::DPR_S_SREF: begin
            // Exit is asynchronous in the part; here any edge with CKE high ends it.
            if (bus.cke) begin
               n.st = dpr_pkg::DPR_S_NORM;
               n.dll_on = 1'b1;
               n.buf_on = 1'b1;
            end
         end
      endcase
      // Low-power current applies only once pending row, precharge or refresh work ends.
      n.lp_ok = (n.st != dpr_pkg::DPR_S_NORM) && (n.op_cnt == 8'h00);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   assign dev_state = r.st;
   assign bank_open = r.open;
   assign dll_on = r.dll_on;
   assign buf_on = r.buf_on;
   assign lp_ok = r.lp_ok;
   assign ref_row = r.ref_row;
   assign mr_sel = r.mr_sel;
   assign mr_op = r.mr_op;
   assign cmd_code = r.cmd;

endmodule : dpr_dev

// ==== dpr_params.svh ====
// Timing and encoding constants shared by both ends of the DDR2 command link.
// Assumes a 40 MHz command clock; tRTP, tWR, tRP and tRFC cycle counts derive from picosecond figures.
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH

`define DPR_TCK_PS 25000
`define DPR_AL 0
`define DPR_BL 4
`define DPR_CL 3
`define DPR_WL (`DPR_AL + `DPR_CL - 1)
`define DPR_TRTP_PS 7500
`define DPR_TWR_PS 15000
`define DPR_TRP_PS 15000
`define DPR_TRFC_PS 127500
// Least times round up to whole cycles.
`define DPR_CEIL(ps) (((ps) + `DPR_TCK_PS - 1) / `DPR_TCK_PS)
`define DPR_RTP `DPR_CEIL(`DPR_TRTP_PS)
`define DPR_WR `DPR_CEIL(`DPR_TWR_PS)
`define DPR_TRP `DPR_CEIL(`DPR_TRP_PS)
`define DPR_TRFC `DPR_CEIL(`DPR_TRFC_PS)
`define DPR_RD_PRE (`DPR_AL + `DPR_BL / 2 + ((`DPR_RTP > 2) ? `DPR_RTP : 2) - 2)
`define DPR_WR_PRE (`DPR_WL + `DPR_BL / 2 + `DPR_WR)
`define DPR_PRE_PRE 1
`define DPR_TCKE 3
`define DPR_TXP 2
`define DPR_FREQ_WAIT 2
`define DPR_DLL_LOCK 200
`define DPR_REF_WIN_MS 64
`define DPR_REF_WIN_CYC (`DPR_REF_WIN_MS * 1000000 / (`DPR_TCK_PS / 1000))
`define DPR_ROWS 8192
`define DPR_PD_MAX_REFI 9
`define DPR_A10 10
`define DPR_DLL_RST_BIT 8
`define DPR_SLOW_EXIT_BIT 12

`endif

// ==== dpr_pkg.sv ====
// Types shared by the controller end and the device end of the command link.
// Holds no timing figures; those stay in the parameter header.
package dpr_pkg;

   typedef enum logic [3:0] {
      DPR_C_NOP = 4'h0,
      DPR_C_DSL = 4'h1,
      DPR_C_ACT = 4'h2,
      DPR_C_PRE = 4'h3,
      DPR_C_PREA = 4'h4,
      DPR_C_WR = 4'h5,
      DPR_C_WRA = 4'h6,
      DPR_C_RD = 4'h7,
      DPR_C_RDA = 4'h8,
      DPR_C_MRS = 4'h9,
      DPR_C_REF = 4'hA
   } dpr_cmd_t;

   typedef enum logic [3:0] {
      DPR_Q_ACT = 4'h0,
      DPR_Q_RD = 4'h1,
      DPR_Q_WR = 4'h2,
      DPR_Q_PRE = 4'h3,
      DPR_Q_MRS = 4'h4,
      DPR_Q_REF = 4'h5,
      DPR_Q_PDE = 4'h6,
      DPR_Q_PDX = 4'h7
   } dpr_req_t;

   typedef enum logic [1:0] {
      DPR_S_NORM = 2'h0,
      DPR_S_PPD = 2'h1,
      DPR_S_APD = 2'h3,
      DPR_S_SREF = 2'h2
   } dpr_state_t;

   function automatic dpr_cmd_t dpr_decode(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n,
                                           input logic a10);
      dpr_cmd_t c;
      c = DPR_C_NOP;
      if (cs_n) begin
         c = DPR_C_DSL;
      end else begin
         unique case ({ras_n, cas_n, we_n})
            3'b011: c = DPR_C_ACT;
            3'b010: c = a10 ? DPR_C_PREA : DPR_C_PRE;
            3'b100: c = a10 ? DPR_C_WRA : DPR_C_WR;
            3'b101: c = a10 ? DPR_C_RDA : DPR_C_RD;
            3'b000: c = DPR_C_MRS;
            3'b001: c = DPR_C_REF;
            3'b111: c = DPR_C_NOP;
            3'b110: c = DPR_C_NOP;
         endcase
      end
      return c;
   endfunction : dpr_decode

endpackage : dpr_pkg

// ==== tb_ddr2_precharge_refresh_powerdown.sv ====
// Bench for the two link ends: drives the controller user side at falling
// edges and checks the device end against a queue model of issued commands.
`timescale 1ns/1ps
`include "dpr_params.svh"
module tb_ddr2_precharge_refresh_powerdown;
   localparam int WIN = 81920;
   localparam int REFI = WIN / `DPR_ROWS;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic [1:0] cmd_bank = 2'h0;
   logic cmd_a10 = 1'b0;
   logic [12:0] cmd_addr = 13'h0000;
   logic odt_req = 1'b0;
   logic clk_chg = 1'b0;
   logic dll_locked = 1'b1;
   logic cmd_ready, ref_due, in_pd, freq_ok, dll_rst_need, dll_on, buf_on, lp_ok;
   logic [1:0] dev_state, mr_sel;
   logic [3:0] bank_open, cmd_code;
   logic [12:0] ref_row, mr_op, ad;
   logic [7:0] rnd = 8'h47;
   logic [3:0] m_open = 4'h0;
   logic [3:0] expq[$];
   int t_of[16];
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int m_refs = 0;
   int n;
   int t0;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   dpr_bus i_dpr_bus ();
   dpr_ctl #(.REF_WIN_CYC(WIN)) i_dpr_ctl (.mclk(mclk), .sys_rst(sys_rst), .bus(i_dpr_bus),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_bank(cmd_bank), .cmd_a10(cmd_a10),
      .cmd_addr(cmd_addr), .dll_locked(dll_locked), .odt_req(odt_req), .clk_chg(clk_chg),
      .cmd_ready(cmd_ready), .ref_due(ref_due), .in_pd(in_pd), .freq_ok(freq_ok),
      .dll_rst_need(dll_rst_need));
   dpr_dev i_dpr_dev (.mclk(mclk), .sys_rst(sys_rst), .bus(i_dpr_bus), .dev_state(dev_state),
      .bank_open(bank_open), .dll_on(dll_on), .buf_on(buf_on), .lp_ok(lp_ok),
      .ref_row(ref_row), .mr_sel(mr_sel), .mr_op(mr_op), .cmd_code(cmd_code));
   dpr_assertions i_dpr_assertions (.mclk(mclk), .sys_rst(sys_rst), .cke(i_dpr_bus.cke),
      .cs_n(i_dpr_bus.cs_n), .ras_n(i_dpr_bus.ras_n), .cas_n(i_dpr_bus.cas_n),
      .we_n(i_dpr_bus.we_n), .odt(i_dpr_bus.odt), .ba(i_dpr_bus.ba), .addr(i_dpr_bus.addr));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [12:0] r13();
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      return {rnd[4:0], rnd};
   endfunction : r13
   function automatic logic [3:0] ecode(input logic [3:0] q, input logic a);
      case (q)
         4'h0: return dpr_pkg::DPR_C_ACT;
         4'h1: return a ? dpr_pkg::DPR_C_RDA : dpr_pkg::DPR_C_RD;
         4'h2: return a ? dpr_pkg::DPR_C_WRA : dpr_pkg::DPR_C_WR;
         4'h3: return a ? dpr_pkg::DPR_C_PREA : dpr_pkg::DPR_C_PRE;
         4'h4: return dpr_pkg::DPR_C_MRS;
         default: return dpr_pkg::DPR_C_REF;
      endcase
   endfunction : ecode
   function automatic logic [12:0] sig(input int s);
      case (s)
         0: return {12'h000, cmd_ready};
         1: return 13'(expq.size());
         2: return {11'h000, dev_state};
         3: return {12'h000, lp_ok};
         default: return {12'h000, freq_ok};
      endcase
   endfunction : sig
   task automatic give_verdict;
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Every wait is bounded; running out is a failure, never a hang.
   task automatic wt(input int s, input logic [12:0] v);
      n = 0;
      while (sig(s) !== v && n < 200) begin
         @(negedge mclk);
         n++;
      end
      if (sig(s) !== v) begin
         num_errors++;
         give_verdict();
      end
   endtask : wt
   task automatic drain;
      wt(1, 13'h0000);
      @(negedge mclk);
   endtask : drain
   // Valid drops one negedge after the take and rises a negedge later, so no
   // signal is written twice in one time step between back-to-back requests.
   task automatic issue(input logic [3:0] q, input logic [1:0] b, input logic a,
                        input logic [12:0] d);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd = q;
      cmd_bank = b;
      cmd_a10 = a;
      cmd_addr = d;
      odt_req = rnd[1];
      wt(0, 13'h0001);
      @(negedge mclk);
      cmd_valid = 1'b0;
      if (q < 4'h6) begin
         expq.push_back(ecode(q, a));
      end
      case (q)
         4'h0: m_open[b] = 1'b1;
         4'h1, 4'h2: m_open[b] = a ? 1'b0 : m_open[b];
         4'h3: m_open = a ? 4'h0 : m_open & ~(4'h1 << b);
         4'h5: m_refs++;
         default: ;
      endcase
   endtask : issue
   always @(negedge mclk) begin
      if (!sys_rst && cmd_code !== dpr_pkg::DPR_C_NOP && cmd_code !== dpr_pkg::DPR_C_DSL) begin
         chk("cmd_code", (expq.size() > 0) ? expq.pop_front() : 4'hF, cmd_code);
         t_of[cmd_code] = cyc;
      end
   end
   initial begin
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      for (int b = 0; b < 4; b++) begin
         issue(4'h0, 2'(b), 1'b0, r13());
      end
      drain();
      chk("bank_open", m_open, bank_open);
      issue(4'h1, 2'h0, 1'b0, r13());
      issue(4'h3, 2'h0, 1'b0, 13'h0000);
      drain();
      chk("rd_pre", 13'h0001, 13'(t_of[3] - t_of[7] >= `DPR_RD_PRE));
      issue(4'h2, 2'h1, 1'b0, r13());
      issue(4'h3, 2'h1, 1'b0, 13'h0000);
      drain();
      chk("wr_pre", 13'h0001, 13'(t_of[3] - t_of[5] >= `DPR_WR_PRE));
      issue(4'h1, 2'h3, 1'b1, 13'h0400);
      issue(4'h2, 2'h2, 1'b1, 13'h0400);
      issue(4'h3, 2'h0, 1'b1, 13'h0400);
      drain();
      chk("wra_prea", 13'h0001, 13'(t_of[4] - t_of[6] >= `DPR_WR_PRE));
      chk("rda_prea", 13'h0001, 13'(t_of[4] - t_of[8] >= `DPR_RD_PRE));
      chk("bank_open", m_open, bank_open);
      issue(4'h5, 2'h0, 1'b0, r13());
      issue(4'h5, 2'h0, 1'b0, r13());
      drain();
      chk("ref_row", 13'(m_refs), ref_row);
      chk("ref_due", 13'h0000, {12'h000, ref_due});
      for (int b = 3; b >= 0; b--) begin
         ad = (b > 1) ? r13() : 13'h0000;
         issue(4'h4, 2'(b), ad[10], ad);
         drain();
         chk("mr_sel", 13'(b), {11'h000, mr_sel});
         chk("mr_op", ad, mr_op);
      end
      issue(4'h6, 2'h0, 1'b0, 13'h0000);
      wt(2, 13'h0001);
      chk("ppd_dll", 13'h0000, {12'h000, dll_on});
      chk("ppd_buf", 13'h0000, {12'h000, buf_on});
      chk("in_pd", 13'h0001, {12'h000, in_pd});
      wt(3, 13'h0001);
      chk("lp_ok", 13'h0001, {12'h000, lp_ok});
      odt_req = 1'b0;
      wt(4, 13'h0001);
      clk_chg = 1'b1;
      @(negedge mclk);
      clk_chg = 1'b0;
      chk("dll_rst_need", 13'h0001, {12'h000, dll_rst_need});
      issue(4'h7, 2'h0, 1'b0, 13'h0000);
      wt(2, 13'h0000);
      chk("exit_buf", 13'h0001, {12'h000, buf_on});
      issue(4'h4, 2'h0, 1'b0, 13'(1 << `DPR_DLL_RST_BIT));
      drain();
      chk("dll_reset", 13'h0000, {12'h000, dll_rst_need});
      odt_req = 1'b1;
      @(negedge mclk);
      chk("odt_relock", 13'h0000, {12'h000, i_dpr_bus.odt});
      issue(4'h0, 2'h0, 1'b0, r13());
      drain();
      dll_locked = 1'b0;
      issue(4'h6, 2'h0, 1'b0, 13'h0000);
      wt(2, 13'h0003);
      chk("apd_dll", 13'h0001, {12'h000, dll_on});
      chk("apd_freq", 13'h0000, {12'h000, freq_ok});
      chk("dll_unlocked", 13'h0001, {12'h000, dll_rst_need});
      t0 = cyc;
      wt(2, 13'h0000);
      chk("pd_long", 13'h0001, 13'((cyc - t0) <= 9 * REFI + 8));
      chk("pd_short", 13'h0001, 13'((cyc - t0) >= 9 * REFI - 8));
      chk("ref_due", 13'h0001, {12'h000, ref_due});
      issue(4'h3, 2'h0, 1'b1, 13'h0400);
      drain();
      chk("bank_open", m_open, bank_open);
      give_verdict();
   end
endmodule : tb_ddr2_precharge_refresh_powerdown
